// ### hw/afm_pkg.sv
// afm_pkg: constants, codes and types shared by the amplifier fault manager
// assumes: single system clock, one active-low asynchronous reset
package afm_pkg;

	// =====================================================
	// fault input positions in the fault vector
	localparam int NFLT = 4;
	localparam int FI_MINOR = 0;
	localparam int FI_MAJOR = 1;
	localparam int FI_OT = 2;
	localparam int FI_CRIT = 3;

	// =====================================================
	// operator command positions, placed above the faults
	localparam int NCMD = 5;
	localparam int CI_PANEL = 4;
	localparam int CI_DIAG_EN = 5;
	localparam int CI_DIAG_DIS = 6;
	localparam int CI_REM_EN = 7;
	localparam int CI_REM_DIS = 8;
	localparam int NPIN = NFLT + NCMD;

	// =====================================================
	// retry and timing defaults
	localparam int RETRY_GEN = 3;
	localparam int RETRY_OT = 1;
	localparam int HYST_DEF = 1000;
	localparam int RST_PULSE_DEF = 16;
	localparam int SETTLE_DEF = 256;

	// =====================================================
	// severity classes, escalating
	typedef enum logic [1:0] {
		SEV_NONE = 2'h0,
		SEV_MINOR = 2'h1,
		SEV_MAJOR = 2'h2,
		SEV_CRIT = 2'h3
	} afm_sev_t;

	// =====================================================
	// major-fault retry sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RST = 4'h2,
		ST_WAIT = 4'h4,
		ST_HOLD = 4'h8
	} afm_state_t;

endpackage : afm_pkg

// ### hw/afm_flt_if.sv
// afm_flt_if: raw and qualified fault levels between manager and filter
// assumes: both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface afm_flt_if #(parameter int N = 4);
	logic [N-1:0] raw;
	logic [N-1:0] qual;
	// manager side
	modport src(output raw, input qual);
	// filter side
	modport flt(input raw, output qual);
endinterface : afm_flt_if
`default_nettype wire

// ### hw/afm_persist.sv
// afm_persist: persistence filter, one counter per fault line
// assumes: raw levels are already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module afm_persist #(
	parameter int N = 4,
	parameter int HYST = 1000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fault levels
	afm_flt_if.flt fl
);
	import afm_pkg::*;

	localparam int CW = $clog2(HYST + 2);
	localparam logic [CW-1:0] LIM = CW'(HYST + 1);
	localparam logic [CW-1:0] HYS = CW'(HYST);

	logic [CW-1:0] cnt_q [N];
	logic [CW-1:0] cnt_d [N];
	logic [N-1:0] qual_q;
	logic [N-1:0] qual_d;

	// =====================================================
	// counters: restart on any gap, saturate at the limit
	// persistence count
	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (!fl.raw[i]) begin
				cnt_d[i] = '0;
			end else if (cnt_q[i] == LIM) begin
				cnt_d[i] = cnt_q[i];
			end else begin
				cnt_d[i] = cnt_q[i] + 1'b1;
			end
			qual_d[i] = fl.raw[i] && (cnt_q[i] >= HYS);
		end
	end

	// registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				cnt_q[i] <= '0;
			end
			qual_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			qual_q <= qual_d;
		end
	end

	assign fl.qual = qual_q; // qualified level drops one cycle after the raw one

	// =====================================================
	// checks
	for (genvar g = 0; g < N; g++) begin : g_chk
		property p_short;
			@(posedge clk) disable iff (!rst_n)
			!fl.raw[g] |=> !fl.qual[g];
		endproperty
		a_short: assert property (p_short)
			else $error("qualified fault outlived its raw level");
		property p_long;
			@(posedge clk) disable iff (!rst_n)
			$rose(fl.qual[g]) |-> $past(cnt_q[g]) >= HYS;
		endproperty
		a_long: assert property (p_long)
			else $error("fault qualified before the hysteresis interval");
	end

endmodule : afm_persist
`default_nettype wire

// ### hw/afm_top.sv
// afm_top: fault manager for one amplifier module
// assumes: fault and operator inputs are asynchronous pins; one clock
//
// Behaviour
// - every fault falls in minor, major or critical, escalating in that order
// - minor fault keeps the module in service, raising only the minor alarm
// - minor fault gives notification only, no automatic action
// - major fault sets major alarm and does not disable the unit
// - critical fault disables the unit until an operator enable arrives after the critical fault has cleared
// - major fault triggers module resets, up to three attempts generally
// - major fault still present after retries: keep running, alarm stays
// - over-temperature major fault gets a single reset attempt only
// - over-temperature surviving its reset shuts down until operator restores
// - alarm only after fault persists longer than hysteresis; transients ignored
// - disable from panel switch, diagnostic port or remote is honoured
// - enable from any of the three paths is accepted, fault re-evaluated
`timescale 1ns/1ps
`default_nettype none
module afm_top #(
	parameter int HYST_CYC = afm_pkg::HYST_DEF,
	parameter int RETRY_MAX = afm_pkg::RETRY_GEN,
	parameter int RST_PULSE_CYC = afm_pkg::RST_PULSE_DEF,
	parameter int SETTLE_CYC = afm_pkg::SETTLE_DEF
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// fault detectors, high while the condition is present
	input wire logic FAULT_MINOR,
	input wire logic FAULT_MAJOR,
	input wire logic FAULT_OVERTEMP,
	input wire logic FAULT_CRITICAL,
	// operator controls
	input wire logic PANEL_DISABLE,
	input wire logic DIAG_ENABLE,
	input wire logic DIAG_DISABLE,
	input wire logic REMOTE_ENABLE,
	input wire logic REMOTE_DISABLE,
	// module control
	output logic MODULE_ENABLE,
	output logic MODULE_RESET,
	output logic OUT_OF_SERVICE,
	// alarms
	output logic ALARM_MINOR,
	output logic ALARM_MAJOR,
	output logic ALARM_CRITICAL,
	output afm_pkg::afm_sev_t FAULT_CLASS
);
	import afm_pkg::*;

	localparam int TW = $clog2(RST_PULSE_CYC + SETTLE_CYC + 1);
	localparam int YW = $clog2(RETRY_MAX + 2);
	localparam logic [TW-1:0] T_PULSE = TW'(RST_PULSE_CYC - 1);
	localparam logic [TW-1:0] T_SETTLE = TW'(SETTLE_CYC - 1);
	localparam logic [YW-1:0] Y_GEN = YW'(RETRY_MAX);
	localparam logic [YW-1:0] Y_OT = YW'(RETRY_OT);
	localparam logic [YW-1:0] Y_ONE = YW'(1);

	// =====================================================
	// input synchroniser, two stages plus an edge stage
	logic [NPIN-1:0] pins;
	logic [NPIN-1:0] s1_q;
	logic [NPIN-1:0] s2_q;
	logic [NPIN-1:0] s3_q;

	assign pins = {REMOTE_DISABLE, REMOTE_ENABLE, DIAG_DISABLE, DIAG_ENABLE, PANEL_DISABLE,
		FAULT_CRITICAL, FAULT_OVERTEMP, FAULT_MAJOR, FAULT_MINOR};

	// first stage feeds only the second
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// =====================================================
	// persistence filter
	afm_flt_if #(.N(NFLT)) fi ();
	logic [NFLT-1:0] qual;

	assign fi.raw = s2_q[NFLT-1:0];
	assign qual = fi.qual;

	afm_persist #(.N(NFLT), .HYST(HYST_CYC)) u_persist (
		.clk(MCLK),
		.rst_n(RST_N),
		.fl(fi.flt)
	);

	// =====================================================
	// operator command decode
	logic pnl_dis;
	logic dis_ev;
	logic en_ev;
	logic maj;

	assign pnl_dis = s2_q[CI_PANEL];
	assign dis_ev = (s2_q[CI_DIAG_DIS] & ~s3_q[CI_DIAG_DIS])
		| (s2_q[CI_REM_DIS] & ~s3_q[CI_REM_DIS]);
	// any enable source, panel release included
	assign en_ev = (s2_q[CI_DIAG_EN] & ~s3_q[CI_DIAG_EN])
		| (s2_q[CI_REM_EN] & ~s3_q[CI_REM_EN])
		| (~s2_q[CI_PANEL] & s3_q[CI_PANEL]);
	assign maj = qual[FI_MAJOR] | qual[FI_OT];

	// =====================================================
	// major-fault retry sequencer
	afm_state_t st_q;
	afm_state_t st_d;
	logic [TW-1:0] tmr_q;
	logic [TW-1:0] tmr_d;
	logic [YW-1:0] try_q;
	logic [YW-1:0] try_d;
	logic ot_q;
	logic ot_d;
	logic rst_q;
	logic rst_d;
	logic ot_trip;

	// next state of the sequencer
	always_comb begin
		st_d = st_q;
		tmr_d = tmr_q;
		try_d = try_q;
		ot_d = ot_q;
		rst_d = 1'b0;
		ot_trip = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (maj && MODULE_ENABLE) begin
					st_d = ST_RST;
					tmr_d = T_PULSE;
					try_d = Y_ONE;
					ot_d = qual[FI_OT];
				end
			end
			ST_RST: begin
				rst_d = 1'b1;
				if (tmr_q == '0) begin
					st_d = ST_WAIT;
					tmr_d = T_SETTLE;
				end else begin
					tmr_d = tmr_q - 1'b1;
				end
			end
			ST_WAIT: begin
				if (tmr_q != '0) begin
					tmr_d = tmr_q - 1'b1;
				end else if (!maj) begin
					st_d = ST_IDLE;
				end else if ((ot_q || qual[FI_OT]) && try_q >= Y_OT) begin
					ot_trip = 1'b1;
					st_d = ST_IDLE;
				end else if (try_q < Y_GEN) begin
					st_d = ST_RST;
					tmr_d = T_PULSE;
					try_d = try_q + 1'b1;
				end else begin
					st_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (!maj) begin
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= ST_IDLE;
			tmr_q <= '0;
			try_q <= '0;
			ot_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			try_q <= try_d;
			ot_q <= ot_d;
			rst_q <= rst_d;
		end
	end

	// =====================================================
	// enable, service state and alarms
	logic en_d;
	logic oos_d;
	logic amin_d;
	logic amaj_d;
	logic acrit_d;
	afm_sev_t cls_d;

	// trip beats enable; disable beats enable
	always_comb begin
		en_d = MODULE_ENABLE;
		oos_d = OUT_OF_SERVICE;
		if (en_ev) begin
			en_d = 1'b1;
			oos_d = 1'b0;
		end
		if (dis_ev || pnl_dis) begin
			en_d = 1'b0;
		end
		if (qual[FI_CRIT] || ot_trip) begin
			en_d = 1'b0;
			oos_d = 1'b1;
		end
		amin_d = qual[FI_MINOR];
		amaj_d = maj;
		acrit_d = qual[FI_CRIT] | oos_d;
		if (acrit_d) begin
			cls_d = SEV_CRIT;
		end else if (maj) begin
			cls_d = SEV_MAJOR;
		end else if (qual[FI_MINOR]) begin
			cls_d = SEV_MINOR;
		end else begin
			cls_d = SEV_NONE;
		end
	end

	// output registers; unit comes up enabled
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			MODULE_ENABLE <= 1'b1;
			OUT_OF_SERVICE <= 1'b0;
			ALARM_MINOR <= 1'b0;
			ALARM_MAJOR <= 1'b0;
			ALARM_CRITICAL <= 1'b0;
			FAULT_CLASS <= SEV_NONE;
		end else begin
			MODULE_ENABLE <= en_d;
			OUT_OF_SERVICE <= oos_d;
			ALARM_MINOR <= amin_d;
			ALARM_MAJOR <= amaj_d;
			ALARM_CRITICAL <= acrit_d;
			FAULT_CLASS <= cls_d;
		end
	end

	assign MODULE_RESET = rst_q;

	// =====================================================
	// checks
	property p_class;
		@(posedge MCLK) disable iff (!RST_N)
		qual[FI_CRIT] |=> FAULT_CLASS == SEV_CRIT;
	endproperty
	a_class: assert property (p_class)
		else $error("critical fault not classed critical");

	property p_minor_keep;
		@(posedge MCLK) disable iff (!RST_N)
		MODULE_ENABLE && !qual[FI_CRIT] && !ot_trip && !dis_ev && !pnl_dis |=> MODULE_ENABLE;
	endproperty
	a_minor_keep: assert property (p_minor_keep)
		else $error("module dropped without a cause");

	property p_major_alarm;
		@(posedge MCLK) disable iff (!RST_N)
		qual[FI_MAJOR] |=> ALARM_MAJOR;
	endproperty
	a_major_alarm: assert property (p_major_alarm)
		else $error("major fault without major alarm");

	property p_crit_trip;
		@(posedge MCLK) disable iff (!RST_N)
		qual[FI_CRIT] |=> !MODULE_ENABLE && OUT_OF_SERVICE && ALARM_CRITICAL;
	endproperty
	a_crit_trip: assert property (p_crit_trip)
		else $error("critical fault left the unit enabled");

	property p_oos_hold;
		@(posedge MCLK) disable iff (!RST_N)
		OUT_OF_SERVICE && !en_ev |=> OUT_OF_SERVICE;
	endproperty
	a_oos_hold: assert property (p_oos_hold)
		else $error("out of service cleared without an enable");

	property p_retry;
		@(posedge MCLK) disable iff (!RST_N)
		st_q == ST_IDLE && maj && MODULE_ENABLE |=> st_q == ST_RST && try_q == Y_ONE
			##1 MODULE_RESET;
	endproperty
	a_retry: assert property (p_retry)
		else $error("major fault did not start a reset attempt");

	property p_bound;
		@(posedge MCLK) disable iff (!RST_N)
		st_q == ST_RST |-> try_q <= Y_GEN;
	endproperty
	a_bound: assert property (p_bound)
		else $error("too many reset attempts");

	property p_hold;
		@(posedge MCLK) disable iff (!RST_N)
		st_q == ST_HOLD && maj |=> st_q == ST_HOLD && ALARM_MAJOR;
	endproperty
	a_hold: assert property (p_hold)
		else $error("exhausted major fault left hold");

	property p_ot_once;
		@(posedge MCLK) disable iff (!RST_N)
		st_q == ST_RST && ot_q |-> try_q == Y_OT;
	endproperty
	a_ot_once: assert property (p_ot_once)
		else $error("over-temperature retried more than once");

	property p_ot_trip;
		@(posedge MCLK) disable iff (!RST_N)
		ot_trip |=> OUT_OF_SERVICE && !MODULE_ENABLE;
	endproperty
	a_ot_trip: assert property (p_ot_trip)
		else $error("over-temperature did not shut down");

	property p_disable;
		@(posedge MCLK) disable iff (!RST_N)
		dis_ev || pnl_dis |=> !MODULE_ENABLE;
	endproperty
	a_disable: assert property (p_disable)
		else $error("operator disable ignored");

	property p_enable;
		@(posedge MCLK) disable iff (!RST_N)
		en_ev && !dis_ev && !pnl_dis && !qual[FI_CRIT] && !ot_trip
			|=> MODULE_ENABLE && !OUT_OF_SERVICE;
	endproperty
	a_enable: assert property (p_enable)
		else $error("operator enable ignored");

endmodule : afm_top
`default_nettype wire

// ### tb/afm_op_model.sv
// afm_op_model: operator side, panel switch plus diagnostic and remote command lines
// assumes: called from the bench just after a rising clock edge, one command at a time
`timescale 1ns/1ps
`default_nettype none
module afm_op_model (
	// clock
	input wire logic clk,
	// operator lines: cmd 0 diag enable, 1 diag disable, 2 remote enable, 3 remote disable
	output logic panel_disable,
	output logic [3:0] cmd
);

	// =====================================================
	// idle levels at time zero
	initial begin
		panel_disable = 1'b0;
		cmd = 4'h0;
	end

	// =====================================================
	// panel switch level
	task automatic panel(input logic v);
		panel_disable = v;
	endtask : panel

	task automatic pulse(input int k);
		// whole-vector drive keeps every command line a live stimulus
		cmd = 4'h1 << k;
		repeat (2) @(posedge clk);
		#1;
		// low gap so the next rise is seen as an edge
		cmd = 4'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask : pulse

endmodule : afm_op_model
`default_nettype wire

// ### tb/afm_top_tb.sv
// afm_top_tb: self-checking bench for the fault manager
// assumes: short counts set below; the operator model drives the command lines
`timescale 1ns/1ps
`default_nettype none
module afm_top_tb;
	import afm_pkg::*;

	// =====================================================
	// shortened counts
	localparam int HY = 4;
	localparam int PU = 2;
	localparam int SE = 4;
	localparam int RM = 3;

	logic MCLK = 1'b0;
	logic RST_N = 1'b0;
	logic [3:0] flt = 4'h0;
	logic panel;
	logic [3:0] cmd;
	logic m_en, m_rst, oos, a_min, a_maj, a_crit;
	afm_sev_t cls;
	int n_errors = 0;
	int n_checks = 0;
	int n_rst;
	int max_len;
	logic en_low;
	logic al_seen;

	// clock at 125 MHz
	always #4 MCLK = ~MCLK;

	// =====================================================
	// design and operator side
	afm_top #(.HYST_CYC(HY), .RETRY_MAX(RM), .RST_PULSE_CYC(PU), .SETTLE_CYC(SE)) i_dut (
		.MCLK(MCLK), .RST_N(RST_N),
		.FAULT_MINOR(flt[FI_MINOR]), .FAULT_MAJOR(flt[FI_MAJOR]),
		.FAULT_OVERTEMP(flt[FI_OT]), .FAULT_CRITICAL(flt[FI_CRIT]),
		.PANEL_DISABLE(panel), .DIAG_ENABLE(cmd[0]), .DIAG_DISABLE(cmd[1]),
		.REMOTE_ENABLE(cmd[2]), .REMOTE_DISABLE(cmd[3]),
		.MODULE_ENABLE(m_en), .MODULE_RESET(m_rst), .OUT_OF_SERVICE(oos),
		.ALARM_MINOR(a_min), .ALARM_MAJOR(a_maj), .ALARM_CRITICAL(a_crit),
		.FAULT_CLASS(cls)
	);
	afm_op_model i_op (.clk(MCLK), .panel_disable(panel), .cmd(cmd));

	// =====================================================
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask : cyc

	task automatic results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results

	task automatic chk(input logic exp, input logic act, input string msg);
		n_checks++;
		if (act !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk

	task automatic chk_cls(input afm_sev_t exp);
		chk(1'b1, cls === exp, "fault class");
	endtask : chk_cls

	function automatic logic obs(input int k);
		case (k)
			0: return m_en;
			1: return oos;
			2: return a_min;
			3: return a_maj;
			default: return a_crit;
		endcase
	endfunction : obs

	// bounded wait for an output level; running out ends the run
	task automatic wait_obs(input int k, input logic v, input int b);
		for (int i = 0; i < b && obs(k) !== v; i++) cyc(1);
		if (obs(k) !== v) begin
			n_errors++;
			$display("[FAIL] %0t wait on output %0d timed out", $time, k);
			results();
		end else begin
			n_checks++;
		end
	endtask : wait_obs

	// watch n cycles: reset pulses, longest pulse, enable drop, any alarm
	task automatic watch(input int n);
		int len;
		logic prev;
		len = 0;
		prev = m_rst;
		n_rst = 0;
		max_len = 0;
		en_low = 1'b0;
		al_seen = 1'b0;
		repeat (n) begin
			cyc(1);
			if (m_rst === 1'b1 && prev !== 1'b1) n_rst++;
			len = (m_rst === 1'b1) ? len + 1 : 0;
			if (len > max_len) max_len = len;
			if (m_en !== 1'b1) en_low = 1'b1;
			if (a_min !== 1'b0 || a_maj !== 1'b0 || a_crit !== 1'b0) al_seen = 1'b1;
			prev = m_rst;
		end
	endtask : watch

	// =====================================================
	// scenarios
	task automatic t_reset;
		chk(1'b1, m_en, "enable after reset");
		chk(1'b0, m_rst | oos | a_min | a_maj | a_crit, "outputs after reset");
		chk_cls(SEV_NONE);
		$display("test reset done");
	endtask : t_reset

	task automatic t_minor;
		flt[FI_MINOR] = 1'b1;
		cyc(HY);
		flt[FI_MINOR] = 1'b0;
		watch(HY + 8);
		chk(1'b0, al_seen, "transient raised alarm");
		flt[FI_MINOR] = 1'b1;
		wait_obs(2, 1'b1, HY + 8);
		watch(20);
		chk(1'b1, n_rst == 0, "minor caused reset");
		chk(1'b0, en_low, "minor disabled module");
		chk_cls(SEV_MINOR);
		flt[FI_MINOR] = 1'b0;
		wait_obs(2, 1'b0, 6);
		$display("test minor done");
	endtask : t_minor

	task automatic t_major;
		flt[FI_MINOR] = 1'b1;
		flt[FI_MAJOR] = 1'b1;
		wait_obs(3, 1'b1, HY + 8);
		watch(60);
		chk(1'b1, n_rst == RM, "reset attempt count");
		chk(1'b1, max_len == PU, "reset pulse length");
		chk(1'b0, en_low, "major disabled module");
		chk(1'b1, a_maj, "major alarm after retries");
		chk_cls(SEV_MAJOR);
		flt = 4'h0;
		wait_obs(3, 1'b0, 6);
		$display("test major done");
	endtask : t_major

	task automatic t_overtemp;
		flt[FI_OT] = 1'b1;
		wait_obs(3, 1'b1, HY + 8);
		watch(40);
		chk(1'b1, n_rst == 1, "over-temp attempt count");
		chk(1'b1, oos, "over-temp out of service");
		chk(1'b0, m_en, "over-temp still enabled");
		flt[FI_OT] = 1'b0;
		cyc(8);
		chk(1'b1, oos, "shutdown not held");
		i_op.pulse(0);
		wait_obs(0, 1'b1, 6);
		chk(1'b0, oos, "enable left out of service");
		$display("test overtemp done");
	endtask : t_overtemp

	task automatic t_crit;
		flt[FI_CRIT] = 1'b1;
		flt[FI_MINOR] = 1'b1;
		wait_obs(0, 1'b0, HY + 8);
		chk(1'b1, oos & a_crit, "critical indications");
		chk_cls(SEV_CRIT);
		i_op.pulse(2);
		cyc(2);
		chk(1'b0, m_en, "enable over live critical");
		flt = 4'h0;
		cyc(8);
		chk(1'b0, m_en, "critical disable not held");
		i_op.pulse(2);
		wait_obs(0, 1'b1, 6);
		$display("test critical done");
	endtask : t_crit

	task automatic t_disable;
		for (int k = 0; k < 3; k++) begin
			if (k == 0) i_op.panel(1'b1);
			else i_op.pulse(2 * k - 1);
			wait_obs(0, 1'b0, 8);
			if (k == 0) begin
				i_op.pulse(0);
				cyc(4);
				chk(1'b0, m_en, "enable beat held panel");
				i_op.panel(1'b0);
			end else begin
				i_op.pulse(2 * k - 2);
			end
			wait_obs(0, 1'b1, 8);
		end
		$display("test disable done");
	endtask : t_disable

	// =====================================================
	// main sequence
	initial begin
		cyc(8);
		RST_N = 1'b1;
		cyc(1);
		t_reset();
		t_minor();
		t_major();
		t_overtemp();
		t_crit();
		t_disable();
		results();
	end

endmodule : afm_top_tb
`default_nettype wire
